// ### core/spmc_ctrl.sv
// spmc_ctrl: serial controller, master or slave, with transmit buffer
`timescale 1ns/1ns
module spmc_ctrl
  import spmc_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_enable,
  input  wire spmc_cfg_t         i_cfg,
  input  wire spmc_dly_t         i_dly,
  input  wire logic [DATA_W-1:0] i_tx_data,
  input  wire logic              i_tx_data_valid,
  input  wire spmc_opt_t         i_tx_opt,
  input  wire logic              i_tx_ctrl_valid,
  output logic                   o_tx_ready,
  output logic [DATA_W-1:0]      o_rx_data,
  output logic                   o_rx_valid,
  input  wire logic              i_rx_ack,
  output logic [FLAG_N-1:0]      o_flags,
  input  wire logic [FLAG_N-1:0] i_flag_clr,
  input  wire logic [IRQ_N-1:0]  i_irq_en,
  output logic                   o_irq,
  output logic                   o_role_master,
  input  wire logic              i_sck,
  output logic                   o_sck,
  output logic                   o_sck_oe,
  input  wire logic              i_mosi,
  output logic                   o_mosi,
  output logic                   o_mosi_oe,
  input  wire logic              i_miso,
  output logic                   o_miso,
  output logic                   o_miso_oe,
  input  wire logic              i_ssel0,
  output logic [SEL_N-1:0]       o_ssel,
  output logic                   o_ssel_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // shift helpers

  // left-justify msb-first words so the out bit is always at an end
  function automatic logic [DATA_W-1:0] load_sr(input logic [DATA_W-1:0] d,
                                                input logic [3:0] wm1, input logic lsb);
    return lsb ? d : (d << (4'hF - wm1));
  endfunction

  function automatic logic pick_bit(input logic [DATA_W-1:0] sr, input logic lsb);
    return lsb ? sr[0] : sr[DATA_W-1];
  endfunction

  function automatic logic [DATA_W-1:0] shift_sr(input logic [DATA_W-1:0] sr,
                                                 input logic lsb);
    return lsb ? {1'b0, sr[DATA_W-1:1]} : {sr[DATA_W-2:0], 1'b0};
  endfunction

  function automatic logic [DATA_W-1:0] ins_bit(input logic [DATA_W-1:0] rx,
                                                input logic b, input logic lsb);
    return lsb ? {b, rx[DATA_W-1:1]} : {rx[DATA_W-2:0], b};
  endfunction

  // right-align a finished receive word of wm1+1 bits
  function automatic logic [DATA_W-1:0] align_rx(input logic [DATA_W-1:0] rx,
                                                 input logic [3:0] wm1, input logic lsb);
    return lsb ? (rx >> (4'hF - wm1)) : (rx & (16'hFFFF >> (4'hF - wm1)));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic              en_q_ff;
  logic [3:0]        meta_ff;
  logic [3:0]        sync_ff;
  logic              sck_prev_ff;
  spmc_opt_t         opt_ff;
  spmc_state_t       state_ff;
  logic              half_ff;
  logic [3:0]        bitcnt_ff;
  logic [4:0]        dcnt_ff;
  spmc_opt_t         cur_opt_ff;
  logic [DATA_W-1:0] tx_sr_ff;
  logic [DATA_W-1:0] rx_sr_ff;
  logic [DATA_W-1:0] rx_word_ff;
  logic              done_ff;
  logic              done_disc_ff;
  logic              ssel_on_ff;
  logic              sel_prev_ff;
  logic [FLAG_N-1:0] sticky_ff;

  logic              tick;
  logic              fifo_ovalid;
  spmc_txw_t         fifo_odata;
  spmc_txw_t         fifo_idata;
  logic              pop;
  spmc_txw_t         ld_word;
  logic [3:0]        wm1;
  logic              lsb;
  logic              is_master;
  logic              s_sck;
  logic              s_mosi;
  logic              s_miso;
  logic              s_ssel;
  logic              ss_act;
  logic              ss_rise;
  logic              lead_ev;
  logic              trail_ev;
  logic              sample;
  logic              rx_in;
  logic              last_bit;
  logic              word_done;
  logic              load_go;
  logic              gap_zero;
  logic              sel_seen;
  logic              underrun;
  logic [FLAG_N-1:0] set_ev;

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode and pin synchronisers

  assign wm1       = (i_cfg.width_m1 < WM1_MIN) ? WM1_MIN : i_cfg.width_m1;
  assign lsb       = i_cfg.lsb_first;
  assign is_master = o_role_master & en_q_ff;
  assign s_sck     = sync_ff[3];
  assign s_mosi    = sync_ff[2];
  assign s_miso    = sync_ff[1];
  assign s_ssel    = sync_ff[0];

  // two-stage synchroniser for the link pins
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_ff     <= '0;
      sync_ff     <= '0;
      sck_prev_ff <= 1'b0;
    end else begin
      meta_ff     <= {i_sck, i_mosi, i_miso, i_ssel0};
      sync_ff     <= meta_ff;
      sck_prev_ff <= sync_ff[3];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      en_q_ff       <= 1'b0;
      o_role_master <= 1'b0;
    end else begin
      en_q_ff <= i_enable;
      if (i_enable && !en_q_ff) begin
        o_role_master <= i_cfg.master;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      opt_ff <= '0;
    end else if (i_tx_ctrl_valid) begin
      opt_ff <= i_tx_opt;
    end
  end

  // data word takes fresh or standing options
  assign fifo_idata.tx_control_word = i_tx_ctrl_valid ? i_tx_opt : opt_ff;
  assign fifo_idata.data            = i_tx_data;

  spmc_fifo #(
    .W (TXW_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (i_tx_data_valid),
    .o_in_ready  (o_tx_ready),
    .i_in_data   (fifo_idata),
    .o_out_valid (fifo_ovalid),
    .i_out_ready (pop),
    .o_out_data  (fifo_odata)
  );

  // half bit period tick for the master
  spmc_rate_gen u_rate (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_run     (is_master),
    .i_baud_hz (i_cfg.baud_hz),
    .o_tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shared shift engine events

  // slave sees its select through the level setting
  assign ss_act  = en_q_ff & !o_role_master & (s_ssel == i_cfg.select_active_level[0]);
  assign ss_rise = ss_act & !sel_prev_ff;

  // leading edge goes to the active level
  assign lead_ev  = is_master ? (tick & (state_ff == ST_SHIFT) & !half_ff)
                              : (ss_act & (s_sck != sck_prev_ff) & (s_sck != i_cfg.cpol));
  assign trail_ev = is_master ? (tick & (state_ff == ST_SHIFT) & half_ff)
                              : (ss_act & (s_sck != sck_prev_ff) & (s_sck == i_cfg.cpol));

  assign sample    = i_cfg.cpha ? trail_ev : lead_ev;
  // loopback takes our own out bit
  assign rx_in     = i_cfg.loopback ? (is_master ? o_mosi : o_miso)
                                    : (is_master ? s_miso : s_mosi);
  assign last_bit  = (bitcnt_ff == wm1);
  assign word_done = trail_ev & last_bit;
  assign gap_zero  = (dcnt_ff == '0);

  // word load: master from idle or wait, slave on select or word end
  assign load_go  = is_master ? (((state_ff == ST_IDLE) || (state_ff == ST_WAIT)) & fifo_ovalid)
                              : (ss_rise | (word_done & ss_act));
  assign pop      = load_go & fifo_ovalid;
  assign ld_word  = fifo_ovalid ? fifo_odata : '0;
  // slave must shift with nothing buffered
  assign underrun = !is_master & load_go & !fifo_ovalid;

  // shift registers, load, shift and sample
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_sr_ff   <= '0;
      rx_sr_ff   <= '0;
      bitcnt_ff  <= '0;
      half_ff    <= 1'b0;
      cur_opt_ff <= '0;
    end else begin
      if (sample) begin
        rx_sr_ff <= ins_bit(rx_sr_ff, rx_in, lsb);
      end
      if (load_go) begin
        tx_sr_ff   <= load_sr(ld_word.data, wm1, lsb);
        cur_opt_ff <= ld_word.tx_control_word;
        bitcnt_ff  <= '0;
        half_ff    <= 1'b0;
      end else if (lead_ev) begin
        half_ff <= 1'b1;
        // late phase moves data at leading edge
        if (i_cfg.cpha && bitcnt_ff != '0) begin
          tx_sr_ff <= shift_sr(tx_sr_ff, lsb);
        end
      end else if (trail_ev) begin
        half_ff   <= 1'b0;
        bitcnt_ff <= last_bit ? 4'h0 : bitcnt_ff + 4'h1;
        if (!i_cfg.cpha && !last_bit) begin
          tx_sr_ff <= shift_sr(tx_sr_ff, lsb);
        end
      end
    end
  end

  // finished word captured for delivery next cycle
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      done_ff      <= 1'b0;
      done_disc_ff <= 1'b0;
      rx_word_ff   <= '0;
    end else begin
      done_ff      <= word_done;
      done_disc_ff <= cur_opt_ff.discard_rx_option;
      if (word_done) begin
        rx_word_ff <= align_rx(sample ? ins_bit(rx_sr_ff, rx_in, lsb) : rx_sr_ff, wm1, lsb);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master sequencer

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff   <= ST_IDLE;
      dcnt_ff    <= '0;
      ssel_on_ff <= 1'b0;
    end else if (!is_master) begin
      state_ff   <= ST_IDLE;
      dcnt_ff    <= '0;
      ssel_on_ff <= 1'b0;
    end else begin
      // gap counts two ticks per serial period
      if (!gap_zero && tick) begin
        dcnt_ff <= dcnt_ff - 5'h1;
      end
      unique case (state_ff)
        ST_IDLE: begin
          if (load_go) begin
            ssel_on_ff <= 1'b1;
            dcnt_ff    <= {i_dly.select_to_clock_gap, 1'b0};
            state_ff   <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (gap_zero) begin
            state_ff <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (word_done) begin
            if (cur_opt_ff.transfer_end_option) begin
              dcnt_ff  <= {i_dly.clock_to_deselect_gap, 1'b0};
              state_ff <= ST_POST;
            // frame end inserts the word gap
            end else if (cur_opt_ff.frame_end_option) begin
              dcnt_ff  <= {i_dly.inter_word_gap, 1'b0};
              state_ff <= ST_FGAP;
            end else begin
              state_ff <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (load_go) begin
            state_ff <= ST_SHIFT;
          end
        end
        ST_FGAP: begin
          if (gap_zero) begin
            state_ff <= ST_WAIT;
          end
        end
        ST_POST: begin
          if (gap_zero) begin
            ssel_on_ff <= 1'b0;
            dcnt_ff    <= {i_dly.inter_transfer_gap, 1'b0};
            state_ff   <= ST_XGAP;
          end
        end
        ST_XGAP: begin
          if (gap_zero) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ssel    <= '0;
      o_ssel_oe <= 1'b0;
      o_sck     <= 1'b0;
      o_sck_oe  <= 1'b0;
      o_mosi    <= 1'b0;
      o_mosi_oe <= 1'b0;
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      for (int i = 0; i < SEL_N; i++) begin
        o_ssel[i] <= (ssel_on_ff && !i_cfg.ssel_none && i_cfg.ssel_num == 2'(i))
                     ? i_cfg.select_active_level[i] : !i_cfg.select_active_level[i];
      end
      o_ssel_oe <= is_master;
      o_sck_oe  <= is_master;
      o_mosi_oe <= is_master;
      if (!is_master || state_ff != ST_SHIFT) begin
        o_sck <= i_cfg.cpol;
      end else if (lead_ev) begin
        o_sck <= !i_cfg.cpol;
      end else if (trail_ev) begin
        o_sck <= i_cfg.cpol;
      end
      o_mosi    <= pick_bit(tx_sr_ff, lsb);
      o_miso    <= pick_bit(tx_sr_ff, lsb);
      o_miso_oe <= ss_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive holding register and status

  // select as seen in either role
  assign sel_seen = is_master ? (ssel_on_ff & !i_cfg.ssel_none) : ss_act;

  always_comb begin
    set_ev                 = '0;
    set_ev[FLG_RX_OVF]     = done_ff & !done_disc_ff & o_rx_valid & !i_rx_ack;
    set_ev[FLG_TX_STARVED] = underrun;
    set_ev[FLG_SEL_ON]     = sel_seen & !sel_prev_ff;
    set_ev[FLG_SEL_OFF]    = !sel_seen & sel_prev_ff;
    set_ev[FLG_XFER_DONE]  = is_master ? ((state_ff == ST_POST) & gap_zero)
                                       : (!sel_seen & sel_prev_ff);
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rx_data   <= '0;
      o_rx_valid  <= 1'b0;
      sel_prev_ff <= 1'b0;
    end else begin
      sel_prev_ff <= sel_seen;
      if (done_ff && !done_disc_ff) begin
        o_rx_data  <= rx_word_ff;
        o_rx_valid <= 1'b1;
      end else if (i_rx_ack) begin
        o_rx_valid <= 1'b0;
      end
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sticky_ff <= '0;
    end else begin
      sticky_ff <= (sticky_ff & ~i_flag_clr) | set_ev;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_flags <= '0;
      o_irq   <= 1'b0;
    end else begin
      o_flags                 <= sticky_ff;
      o_flags[FLG_RX_READY]   <= o_rx_valid;
      o_flags[FLG_TX_READY]   <= o_tx_ready;
      o_flags[FLG_STALLED]    <= is_master & (state_ff == ST_WAIT) & !fifo_ovalid;
      o_flags[FLG_IDLE]       <= !is_master | ((state_ff == ST_IDLE) & !fifo_ovalid);
      o_irq                   <= |(o_flags[IRQ_N-1:0] & i_irq_en);
    end
  end

endmodule

// ### core/spmc_fifo.sv
// spmc_fifo: synchronous valid/ready fifo for transmit words
`timescale 1ns/1ns
module spmc_fifo #(
  parameter int W = 19,
  parameter int D = 8
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   cnt_ff;
  logic [AW:0]   nxt_cnt;
  logic          push;
  logic          pop;

  // handshake on both sides
  assign push       = i_in_valid & o_in_ready;
  assign pop        = o_out_valid & i_out_ready;
  assign o_out_data = mem[rd_ptr_ff];

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  // storage write
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= i_in_data;
    end
  end

  // pointers, count and registered full/empty
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr_ff   <= '0;
      rd_ptr_ff   <= '0;
      cnt_ff      <= '0;
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(D - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(D - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      cnt_ff      <= nxt_cnt;
      o_in_ready  <= (nxt_cnt != (AW+1)'(D));
      o_out_valid <= (nxt_cnt != '0);
    end
  end
endmodule

// ### core/spmc_pkg.sv
// spmc_pkg: shared constants, types and states of the serial controller
package spmc_pkg;

  // source clock and word geometry
  localparam int unsigned SRC_CLK_HZ = 50_000_000;
  localparam int          DATA_W     = 16;
  localparam int          FIFO_DEPTH = 8;
  localparam int          DLY_W      = 4;
  localparam logic [3:0]  DLY_MAX    = 4'hF;
  localparam logic [3:0]  WM1_MIN    = 4'h3;
  localparam logic [3:0]  WM1_MAX    = 4'hF;
  localparam int          SEL_N      = 4;

  // status flag positions
  localparam int FLG_RX_READY   = 0;
  localparam int FLG_TX_READY   = 1;
  localparam int FLG_RX_OVF     = 2;
  localparam int FLG_TX_STARVED = 3;
  localparam int FLG_SEL_ON     = 4;
  localparam int FLG_SEL_OFF    = 5;
  localparam int FLG_STALLED    = 6;
  localparam int FLG_XFER_DONE  = 7;
  localparam int FLG_IDLE       = 8;
  localparam int FLAG_N         = 9;
  localparam int IRQ_N          = 6;

  // static configuration
  typedef struct packed {
    logic        master;
    logic        cpol;
    logic        cpha;
    logic        lsb_first;
    logic [3:0]  width_m1;
    logic [1:0]  ssel_num;
    logic        ssel_none;
    logic [3:0]  select_active_level;
    logic        loopback;
    logic [31:0] baud_hz;
  } spmc_cfg_t;

  // delays in whole serial clock periods
  typedef struct packed {
    logic [DLY_W-1:0] select_to_clock_gap;
    logic [DLY_W-1:0] clock_to_deselect_gap;
    logic [DLY_W-1:0] inter_word_gap;
    logic [DLY_W-1:0] inter_transfer_gap;
  } spmc_dly_t;

  // per-word options of the tx control word
  typedef struct packed {
    logic frame_end_option;
    logic transfer_end_option;
    logic discard_rx_option;
  } spmc_opt_t;

  // one buffered transmit entry
  typedef struct packed {
    spmc_opt_t         tx_control_word;
    logic [DATA_W-1:0] data;
  } spmc_txw_t;

  localparam int TXW_W = $bits(spmc_txw_t);

  // master sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PRE   = 3'b001,
    ST_SHIFT = 3'b010,
    ST_WAIT  = 3'b011,
    ST_FGAP  = 3'b100,
    ST_POST  = 3'b101,
    ST_XGAP  = 3'b110
  } spmc_state_t;

endpackage

// ### core/spmc_rate_gen.sv
// spmc_rate_gen: half bit period tick from a rate given in hertz
`timescale 1ns/1ns
module spmc_rate_gen
  import spmc_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_run,
  input  wire logic [31:0] i_baud_hz,
  output logic             o_tick
);
  localparam logic [32:0] SRC = 33'(SRC_CLK_HZ);

  logic [31:0] acc_ff;
  logic [32:0] inc;
  logic [32:0] sum;

  // two ticks per bit; rates above half the source clock saturate
  assign inc = ({i_baud_hz, 1'b0} > SRC) ? SRC : {i_baud_hz, 1'b0};
  assign sum = {1'b0, acc_ff} + inc;

  // fractional accumulator, no divider needed
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_ff <= '0;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      acc_ff <= '0;
      o_tick <= 1'b0;
    end else if (sum >= SRC) begin
      acc_ff <= 32'(sum - SRC);
      o_tick <= 1'b1;
    end else begin
      acc_ff <= sum[31:0];
      o_tick <= 1'b0;
    end
  end
endmodule

// ### test/spmc_ctrl_bench.sv
// spmc_ctrl_bench: directed tests of the serial controller in master role
`timescale 1ns/1ns
module spmc_ctrl_bench;
  import spmc_pkg::*;
  logic i_ref_clk = 0, i_sys_rst = 1, i_enable = 0, i_tx_data_valid = 0, i_tx_ctrl_valid = 0;
  logic i_rx_ack = 0, o_tx_ready, o_rx_valid, o_irq, o_role_master, o_sck, o_sck_oe;
  logic o_mosi, o_mosi_oe, i_miso, o_miso, o_miso_oe, o_ssel_oe, i_sck, i_mosi, i_ssel0;
  spmc_cfg_t         i_cfg = '{1'b1, 1'b0, 1'b0, 1'b0, 4'h7, 2'h0, 1'b0, 4'h6, 1'b1, 32'h004C4B40};
  spmc_dly_t         i_dly = 16'h1111;
  spmc_opt_t         i_tx_opt = '0;
  logic [DATA_W-1:0] i_tx_data = '0, o_rx_data;
  logic [FLAG_N-1:0] o_flags, i_flag_clr = '0;
  logic [IRQ_N-1:0]  i_irq_en = 6'h01;
  logic [SEL_N-1:0]  o_ssel;
  logic [7:0]        got;
  int                fails = 0, num_checks = 0;
  // pads loop the driven sck, mosi and select 0 pins back to the pin inputs; miso comes from the far side
  assign i_sck = o_sck;
  assign i_mosi = o_mosi;
  assign i_ssel0 = o_ssel[0];
  spmc_ctrl dut (.*);
  spmc_slave_model u_far (.i_sck(o_sck), .i_mosi(o_mosi), .i_sel(~o_ssel[0]),
    .i_word(8'h5A), .o_miso(i_miso), .o_got(got));
  // clock source
  initial begin
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task push(input logic [15:0] d, input logic [2:0] o);
    @(posedge i_ref_clk);
    i_tx_data <= d;
    i_tx_opt <= o;
    i_tx_data_valid <= 1'b1;
    i_tx_ctrl_valid <= 1'b1;
    @(posedge i_ref_clk);
    i_tx_data_valid <= 1'b0;
    i_tx_ctrl_valid <= 1'b0;
  endtask
  task wait_rx;
    for (int k = 0; k < 3000 && o_rx_valid !== 1'b1; k++) begin
      @(negedge i_ref_clk);
    end
    repeat (2) @(negedge i_ref_clk);
  endtask
  task wait_idle;
    repeat (20) @(negedge i_ref_clk);
    for (int k = 0; k < 4000 && o_flags[FLG_IDLE] !== 1'b1; k++) begin
      @(negedge i_ref_clk);
    end
  endtask
  task ack;
    @(posedge i_ref_clk);
    i_rx_ack <= 1'b1;
    @(posedge i_ref_clk);
    i_rx_ack <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // fill buffer while disabled, then drain discarded words
  task t_fill;
    for (int k = 0; k < 8; k++) begin
      push(16'h00C3, k == 7 ? 3'b011 : 3'b001);
    end
    @(negedge i_ref_clk);
    chk(o_tx_ready, 16'h0000);
    @(posedge i_ref_clk);
    i_enable <= 1'b1;
    wait_idle;
    chk(o_role_master, 16'h0001);
    chk({o_sck_oe, o_mosi_oe, o_ssel_oe, o_miso_oe}, 16'h000E);
    chk(o_flags[FLG_TX_READY], 16'h0001);
    chk(o_rx_valid, 16'h0000);
    chk(o_flags[FLG_XFER_DONE], 16'h0001);
    @(posedge i_ref_clk);
    i_flag_clr <= '1;
    @(posedge i_ref_clk);
    i_flag_clr <= '0;
    repeat (2) @(negedge i_ref_clk);
    chk(o_flags[FLG_XFER_DONE], 16'h0000);
    $display("done fill");
  endtask
  // loopback word, lsb first, mode three
  task t_loop(input logic [3:0] w, input logic [15:0] d, input logic [15:0] e);
    @(posedge i_ref_clk);
    i_cfg <= '{1'b1, 1'b1, 1'b1, 1'b1, w, 2'h0, 1'b0, 4'h6, 1'b1, 32'h004C4B40};
    push(d, 3'b010);
    wait_rx;
    chk(o_rx_data, e);
    chk(o_irq, 16'h0001);
    ack;
    wait_idle;
    chk(o_irq, 16'h0000);
    $display("done loop");
  endtask
  // two words left unread: second overwrites and flags overflow
  task t_ovf;
    push(16'h1111, 3'b000);
    push(16'h2222, 3'b010);
    wait_idle;
    chk(o_flags[FLG_RX_OVF], 16'h0001);
    chk(o_rx_data, 16'h2222);
    ack;
    $display("done ovf");
  endtask
  // word exchanged with the far side, mode zero, msb first
  task t_link;
    @(posedge i_ref_clk);
    i_cfg <= '{1'b1, 1'b0, 1'b0, 1'b0, 4'h7, 2'h0, 1'b0, 4'h6, 1'b0, 32'h004C4B40};
    push(16'h00A5, 3'b010);
    wait_rx;
    wait_idle;
    chk(o_rx_data, 16'h005A);
    chk({8'h00, got}, 16'h00A5);
    ack;
    $display("done link");
  endtask
  task results;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_ref_clk);
    chk(o_tx_ready, 16'h0001);
    t_fill;
    t_loop(4'h7, 16'h1234, 16'h0034);
    t_loop(4'h3, 16'h00B6, 16'h0006);
    t_loop(4'hF, 16'hA5C3, 16'hA5C3);
    t_ovf;
    t_link;
    results;
  end
  // watchdog
  initial begin
    repeat (40000) @(posedge i_ref_clk);
    fails++;
    results;
  end
endmodule

// ### test/spmc_ctrl_monitor.sv
// spmc_ctrl_monitor: port checks of the serial controller
`timescale 1ns/1ns
module spmc_ctrl_monitor
  import spmc_pkg::*;
(
  input wire logic              i_ref_clk,
  input wire logic              i_sys_rst,
  input wire spmc_cfg_t         i_cfg,
  input wire logic              i_rx_ack,
  input wire logic [FLAG_N-1:0] i_flag_clr,
  input wire logic [IRQ_N-1:0]  i_irq_en,
  input wire logic              o_rx_valid,
  input wire logic [FLAG_N-1:0] o_flags,
  input wire logic              o_irq,
  input wire logic              o_role_master,
  input wire logic              o_sck,
  input wire logic              o_sck_oe,
  input wire logic              o_miso_oe,
  input wire logic [SEL_N-1:0]  o_ssel
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // select 0 at its active level in master role
  logic sel_on;
  assign sel_on = o_role_master && (o_ssel[0] == i_cfg.select_active_level[0]);
  ////////////////////////////////////////////////////////////////////////////
  a_irq_from_flags: assert property (o_irq == |($past(o_flags[5:0]) & $past(i_irq_en)))
    else $error("irq differs from enabled flags");
  a_oe_by_role: assert property ($stable(o_role_master) |->
    o_sck_oe == o_role_master && !(o_miso_oe && o_role_master))
    else $error("pin drivers do not follow role");
  a_rx_stands: assert property (o_rx_valid && !i_rx_ack |=> o_rx_valid)
    else $error("rx valid dropped without ack");
  a_done_sticky: assert property (o_flags[FLG_XFER_DONE]
    && !$past(i_flag_clr[FLG_XFER_DONE])
    |=> o_flags[FLG_XFER_DONE])
    else $error("transfer done lost without clear");
  a_sck_rest_level: assert property ($past(o_role_master) && !sel_on && !$past(sel_on)
    && $stable(i_cfg.cpol) |-> o_sck == i_cfg.cpol)
    else $error("serial clock not at rest level");
  a_other_sel_off: assert property ($past(o_role_master, 2) && $stable(i_cfg) |->
    ((o_ssel ^ ~i_cfg.select_active_level) & ~(4'h1 << i_cfg.ssel_num)) == 4'h0)
    else $error("unchosen select not inactive");
  a_sel_on_flag: assert property ($rose(sel_on) && $past(o_role_master, 2)
    |-> ##[1:8] o_flags[FLG_SEL_ON])
    else $error("select assert flag missing");
  a_sel_off_flag: assert property ($fell(sel_on) && $past(o_role_master, 2)
    |-> ##[1:8] o_flags[FLG_SEL_OFF])
    else $error("select deassert flag missing");
  c_rx_acked: cover property (o_rx_valid && i_rx_ack);
  c_sel_rise: cover property ($rose(sel_on));
  c_irq: cover property (o_irq);
endmodule
bind spmc_ctrl spmc_ctrl_monitor u_mon (.*);

// ### test/spmc_slave_model.sv
// spmc_slave_model: far side serial device, clock mode zero, msb first
`timescale 1ns/1ns
module spmc_slave_model (
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_sel,
  input  wire logic [7:0] i_word,
  output logic            o_miso,
  output logic [7:0]      o_got
);
  logic [7:0] sh    = 8'h00;
  logic       sel_q = 1'b0;
  always @(posedge i_sck) begin
    if (i_sel) begin
      o_got = {o_got[6:0], i_mosi};
    end
  end
  // load at select, next bit on falling edge, inverse once released
  always @(posedge i_sel or negedge i_sel or negedge i_sck) begin
    if (i_sel && !sel_q) begin
      sh     = i_word;
      o_miso = i_word[7];
    end else if (i_sel) begin
      sh     = {sh[6:0], 1'b0};
      o_miso = sh[7];
    end else if (sel_q) begin
      o_miso = ~o_miso;
    end
    sel_q = i_sel;
  end
endmodule
